// >>> testbench/apsc_host.sv
// Host model that issues power-state requests
`timescale 1ns/100ps
`default_nettype none
module apsc_host (
  input wire logic clk,
  input wire logic busy,
  output logic req_valid,
  output logic [1:0] req_state
);
  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_state = 2'h0;
  end
  // One request pulse; a polite host waits out the settling time first
  task automatic send(input logic [1:0] code, input bit polite);
    while (polite && busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    req_state = code;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_state = ~code; // Released code is the inverse, so it differs from the code just sent
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_apsc_ctrl.sv
// Testbench of the ADC power-state controller
`timescale 1ns/100ps
`default_nettype none
module tb_apsc_ctrl;
  import apsc_pkg::*;
  localparam int L = 8;
  logic clk, nrst, busy, rej, conv, core, bias, cfg_we, req_valid;
  logic [1:0] req_state, pst;
  logic [3:0] cfg_waddr, cfg_raddr;
  logic [7:0] cfg_wdata, cfg_rdata;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  apsc_ctrl #(.LATENCY_CYC(L)) dut_u (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_state(req_state), .power_state_control(pst), .busy(busy), .req_rejected(rej),
    .conv_enable(conv), .core_power_on(core), .bias_power_on(bias), .cfg_we(cfg_we),
    .cfg_waddr(cfg_waddr), .cfg_wdata(cfg_wdata), .cfg_raddr(cfg_raddr),
    .cfg_rdata(cfg_rdata));
  apsc_host host_u (.clk(clk), .busy(busy), .req_valid(req_valid), .req_state(req_state));
  ////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Step to 1 ns past the next edge, where outputs are settled
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Count edges until settling ends; bounded so a stuck busy cannot hang
  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
  endtask
  // Accepted request: old state holds while settling, then target and supplies
  task automatic go(input logic [1:0] code, input logic [1:0] old);
    host_u.send(code, 1'b1);
    check("busy", 8'(busy), 8'h01);
    check("early state", 8'(pst), 8'(old));
    wait_idle();
    check("latency", 8'(n), 8'(L));
    check("state", 8'(pst), 8'(code));
    tick();
    check("conv", 8'(conv), 8'(code == APSC_ACTIVE));
    check("core", 8'(core), 8'(code != APSC_PDOWN));
    check("bias", 8'(bias), 8'(code != APSC_PDOWN));
  endtask
  // Refused request: pulse one cycle later, state kept
  task automatic refused(input logic [1:0] code, input logic [1:0] st);
    host_u.send(code, 1'b0);
    check("rejected", 8'(rej), 8'h01);
    check("kept state", 8'(pst), 8'(st));
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    cfg_we = 1'b0;
    cfg_waddr = 4'h3;
    cfg_raddr = 4'h3;
    cfg_wdata = 8'h5a;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    check("reset state", 8'(pst), 8'(APSC_ACTIVE));
    check("reset conv", 8'(conv), 8'h01);
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    go(APSC_PDOWN, APSC_ACTIVE);
    refused(APSC_STANDBY, APSC_PDOWN);
    check("idle busy", 8'(busy), 8'h00);
    cfg_wdata = 8'ha5;
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    tick();
    check("cfg", cfg_rdata, 8'h5a);
    go(APSC_ACTIVE, APSC_PDOWN);
    refused(2'h2, APSC_ACTIVE);
    tick();
    host_u.send(APSC_STANDBY, 1'b1);
    tick();
    refused(APSC_PDOWN, APSC_ACTIVE);
    wait_idle();
    check("timer", 8'(n), 8'(L - 2));
    check("standby", 8'(pst), 8'(APSC_STANDBY));
    tick();
    go(APSC_ACTIVE, APSC_STANDBY);
    print_verdict();
  end
  // Watchdog, well beyond the expected run of under 100 cycles
  initial begin
    #5000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> verilog/apsc_cfg_mem.sv
// Configuration register store with registered read data
`timescale 1ns/100ps
`default_nettype none
module apsc_cfg_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port; the caller gates writes while powered down
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> verilog/apsc_ctrl.sv
// ADC power-state controller: requests, settling latency, state reporting
// Behaviour
// - Three states: active, power-down, standby
// - Power-down stops conversion, keeps configuration
// - Standby stops conversion, small power saving
// - Write is request for target state
// - Read returns actual state in force
// - Readback matches request after 15 us
// - Requests during latency may be rejected
// - No direct power-down to standby move
`timescale 1ns/100ps
`default_nettype none
module apsc_ctrl
  import apsc_pkg::*;
#(
  parameter int LATENCY_CYC = apsc_pkg::APSC_LATENCY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [1:0] req_state,
  output logic [1:0] power_state_control,
  output logic busy,
  output logic req_rejected,
  output logic conv_enable,
  output logic core_power_on,
  output logic bias_power_on,
  input wire logic cfg_we,
  input wire logic [apsc_pkg::APSC_CFG_AW-1:0] cfg_waddr,
  input wire logic [apsc_pkg::APSC_CFG_DW-1:0] cfg_wdata,
  input wire logic [apsc_pkg::APSC_CFG_AW-1:0] cfg_raddr,
  output logic [apsc_pkg::APSC_CFG_DW-1:0] cfg_rdata
);
  import apsc_pkg::*;

  localparam logic [APSC_CNT_W-1:0] LAT_LOAD = APSC_CNT_W'(LATENCY_CYC);

  logic [1:0] state_reg;
  logic [1:0] target_reg;
  logic [APSC_CNT_W-1:0] cnt_reg;
  logic accept;
  logic reject;

  // Legal target: known code, and never power-down straight to standby
  function automatic logic legal_target(input logic [1:0] cur, input logic [1:0] tgt);
    legal_target = (tgt != APSC_CODE_RSVD) &&
                   !((cur == APSC_PDOWN) && (tgt == APSC_STANDBY));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request acceptance
  assign accept = req_valid && !busy && legal_target(state_reg, req_state);
  assign reject = req_valid && !accept;

  // Latency timer; a refused request never reloads it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= APSC_CNT_ZERO;
    end else if (accept) begin
      cnt_reg <= LAT_LOAD;
    end else if (cnt_reg != APSC_CNT_ZERO) begin
      cnt_reg <= cnt_reg - APSC_CNT_ONE;
    end
  end

  // Target latched on acceptance, committed when the timer expires
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_reg <= APSC_ACTIVE;
      state_reg <= APSC_ACTIVE;
    end else begin
      if (accept) begin
        target_reg <= req_state;
      end
      if (cnt_reg == APSC_CNT_ONE) begin
        state_reg <= target_reg;
      end
    end
  end

  // Busy flag, rejection pulse and reported state, all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      req_rejected <= 1'b0;
      power_state_control <= APSC_ACTIVE;
    end else begin
      busy <= accept || (cnt_reg > APSC_CNT_ONE);
      req_rejected <= reject;
      power_state_control <= (cnt_reg == APSC_CNT_ONE) ? target_reg : state_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core power controls follow the state in force
  // Standby keeps bias up so the return to active is quick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_enable <= 1'b1;
      core_power_on <= 1'b1;
      bias_power_on <= 1'b1;
    end else begin
      case (power_state_control)
        APSC_ACTIVE: begin
          conv_enable <= 1'b1;
          core_power_on <= 1'b1;
          bias_power_on <= 1'b1;
        end
        APSC_STANDBY: begin
          conv_enable <= 1'b0;
          core_power_on <= 1'b1;
          bias_power_on <= 1'b1;
        end
        default: begin
          conv_enable <= 1'b0;
          core_power_on <= 1'b0;
          bias_power_on <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration store frozen while powered down
  apsc_cfg_mem #(
    .AW(APSC_CFG_AW),
    .DW(APSC_CFG_DW)
  ) u_cfg (
    .clk(clk),
    .we(cfg_we && (state_reg != APSC_PDOWN)),
    .waddr(cfg_waddr),
    .wdata(cfg_wdata),
    .raddr(cfg_raddr),
    .rdata(cfg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_no_pd_to_sb: assert property (@(posedge clk) disable iff (!nrst)
    ($past(power_state_control) == APSC_PDOWN) |-> (power_state_control != APSC_STANDBY))
    else $error("power-down went straight to standby");
  chk_reject_keeps: assert property (@(posedge clk) disable iff (!nrst)
    (req_valid && busy) |=> (req_rejected && $stable(target_reg)))
    else $error("request during latency was not refused");
  chk_sb_in_pd: assert property (@(posedge clk) disable iff (!nrst)
    (req_valid && state_reg == APSC_PDOWN && req_state == APSC_STANDBY)
      |=> req_rejected && state_reg == APSC_PDOWN)
    else $error("standby request left power-down");
  chk_timer_hold: assert property (@(posedge clk) disable iff (!nrst)
    (reject && cnt_reg > APSC_CNT_ONE) |=> (cnt_reg == $past(cnt_reg) - APSC_CNT_ONE))
    else $error("refused request disturbed timer");
  chk_accept_load: assert property (@(posedge clk) disable iff (!nrst)
    accept |=> (cnt_reg == LAT_LOAD) && busy)
    else $error("accepted request did not start latency");
  chk_commit_time: assert property (@(posedge clk) disable iff (!nrst)
    (cnt_reg == APSC_CNT_ONE) |=> (power_state_control == $past(target_reg)))
    else $error("readback missed requested state");
  chk_pd_outputs: assert property (@(posedge clk) disable iff (!nrst)
    (power_state_control == APSC_PDOWN) |=> !conv_enable && !core_power_on)
    else $error("power-down left core running");
  chk_sb_outputs: assert property (@(posedge clk) disable iff (!nrst)
    (power_state_control == APSC_STANDBY) |=> !conv_enable && bias_power_on)
    else $error("standby outputs wrong");
  chk_state_legal: assert property (@(posedge clk) disable iff (!nrst)
    power_state_control != APSC_CODE_RSVD)
    else $error("reserved state reported");
endmodule
`default_nettype wire

// >>> verilog/apsc_pkg.sv
// Package of constants and types for the ADC power-state controller
package apsc_pkg;
  // Requested/reported power-state encodings
  typedef enum logic [1:0] {
    APSC_ACTIVE = 2'h0,
    APSC_PDOWN = 2'h1,
    APSC_STANDBY = 2'h3
  } apsc_pstate_t;
  localparam logic [1:0] APSC_CODE_RSVD = 2'h2;
  // Clock rate and settling latency
  localparam int APSC_CLK_MHZ = 200;
  localparam int APSC_LATENCY_US = 15;
  localparam int APSC_LATENCY_CYC = APSC_LATENCY_US * APSC_CLK_MHZ;
  localparam int APSC_CNT_W = 16;
  // Shadow configuration store size, then latency timer count constants
  localparam int APSC_CFG_AW = 4;
  localparam int APSC_CFG_DW = 8;
  localparam logic [APSC_CNT_W-1:0] APSC_CNT_ZERO = 16'h0000;
  localparam logic [APSC_CNT_W-1:0] APSC_CNT_ONE = 16'h0001;
endpackage
